// ### sils_steer.sv
// Serial input line steering: OR or per-line routing, last read line, descriptor ring index
//
// Overview of operation
// - Steering off: OR all three lines together.
// - Steering off: second engine pair unavailable.
// - Steering on: lines kept separate, no OR.
// - Bits 7:6 pick line for second pair.
// - Bits 5:4 pick line for first pair.
// - Steering off: first pair uses ORed lines.
// - Codec read updates last read line field.
// - Next descriptor index prefetched ahead of use.
// - Descriptor ring has 32 entries, wraps.
`timescale 1ns/1ns
`default_nettype none
module sils_steer
    import sils_pkg::*;
(
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Register port, single byte at a time
    input  wire logic             i_reg_wr,
    input  wire logic             i_reg_rd,
    input  wire logic [7:0]       i_reg_addr,
    input  wire logic [7:0]       i_reg_wdata,
    output logic      [7:0]       o_reg_rdata,
    // Link pins from the codecs
    input  wire logic             i_bit_clock,
    input  wire logic             i_frame_sync,
    input  wire logic [2:0]       i_serial_input_line,
    // Codec read completion from the slot decoder
    input  wire logic             i_read_done,
    input  wire logic [2:0]       i_read_tag,
    // Stream toward the input engines
    output logic                  o_valid,
    output sils_word_t            o_word,
    input  wire logic             i_ready,
    output logic                  o_overrun,
    // Descriptor ring position
    input  wire logic             i_desc_advance,
    output logic      [4:0]       o_cur_index,
    output logic      [4:0]       o_prefetch_index
);
    // Map register and last read line
    sils_ctrl_t ctrl_q;
    sils_sel_t  last_read_q;

    // Pin synchronisers and edge history
    logic [2:0] line_s1_q, line_s2_q;
    logic       bclk_s1_q, bclk_s2_q, bclk_s3_q;
    logic       sync_s1_q, sync_s2_q, sync_s3_q;

    // Shift registers and bit count
    logic [7:0] first_sh_q, second_sh_q;
    logic [2:0] bit_cnt_q;
    logic       steer_word_q;

    // Two-entry buffer: head drives the outputs
    sils_word_t head_q, tail_q;
    logic       head_ok_q, tail_ok_q;

    // Decode and selection
    wire        map_hit    = (i_reg_addr == SILS_MAP_OFFSET);
    wire        map_wr     = i_reg_wr && map_hit;
    wire        map_rd     = i_reg_rd && map_hit;
    wire        bit_edge   = bclk_s3_q && !bclk_s2_q;     // Sample on falling edge
    wire        frame_rise = sync_s2_q && !sync_s3_q;
    wire        or_bit     = |line_s2_q;
    wire        line_f     = (ctrl_q.first_sel == SILS_SEL_RESERVED) ? 1'b0 :
                             line_s2_q[ctrl_q.first_sel];
    wire        line_s     = (ctrl_q.second_sel == SILS_SEL_RESERVED) ? 1'b0 :
                             line_s2_q[ctrl_q.second_sel];
    wire        first_bit  = ctrl_q.steer ? line_f : or_bit;
    wire        second_bit = ctrl_q.steer && line_s;
    wire        word_end   = bit_edge && (bit_cnt_q == SILS_BIT_LAST);
    wire [7:0]  first_nx   = {first_sh_q[6:0], first_bit};
    wire [7:0]  second_nx  = {second_sh_q[6:0], second_bit};
    wire        pop        = head_ok_q && i_ready;
    wire        full       = head_ok_q && tail_ok_q && !pop;
    wire        push       = word_end && !full;
    sils_word_t push_word;
    assign push_word = '{first: first_nx, second: second_nx,
                         second_ok: steer_word_q};

    // Lowest tagged line carried the read data
    wire        tag_any    = |i_read_tag;
    wire [1:0]  tag_code   = i_read_tag[0] ? SILS_SEL_LINE0 :
                             i_read_tag[1] ? SILS_SEL_LINE1 : SILS_SEL_LINE2;

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge i_clock) begin
        line_s1_q <= i_serial_input_line;
        line_s2_q <= line_s1_q;
        bclk_s1_q <= i_bit_clock;
        bclk_s2_q <= bclk_s1_q;
        bclk_s3_q <= bclk_s2_q;
        sync_s1_q <= i_frame_sync;
        sync_s2_q <= sync_s1_q;
        sync_s3_q <= sync_s2_q;
    end

    // Map register and last read line
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl_q      <= sils_ctrl_t'(SILS_MAP_RESET[7:SILS_STEER_BIT]);
            last_read_q <= SILS_MAP_RESET[SILS_LAST_LSB +: 2];
        end else begin
            if (map_wr) begin
                ctrl_q <= sils_ctrl_t'(i_reg_wdata[7:SILS_STEER_BIT]);
            end
            if (i_read_done && tag_any) begin
                last_read_q <= tag_code;
            end
        end
    end

    // Read data registered; bit 2 reads zero
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (map_rd) begin
            o_reg_rdata <= {ctrl_q, 1'b0, last_read_q};
        end
    end

    // Bit assembly; frame start realigns the byte boundary
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            first_sh_q   <= 8'h00;
            second_sh_q  <= 8'h00;
            bit_cnt_q    <= 3'h0;
            steer_word_q <= 1'b0;
        end else if (frame_rise) begin
            bit_cnt_q    <= 3'h0;
            steer_word_q <= ctrl_q.steer;
        end else if (bit_edge) begin
            first_sh_q  <= first_nx;
            second_sh_q <= second_nx;
            bit_cnt_q   <= bit_cnt_q + 3'h1;
            // Steer sampled per word for second_ok only; bit selection follows ctrl_q.steer on every bit
            if (word_end) begin
                steer_word_q <= ctrl_q.steer;
            end
        end
    end

    // Buffer: the link cannot be stalled, so a full buffer flags overrun
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            head_q    <= '0;
            tail_q    <= '0;
            head_ok_q <= 1'b0;
            tail_ok_q <= 1'b0;
            o_overrun <= 1'b0;
        end else begin
            if (pop) begin
                head_q    <= tail_ok_q ? tail_q : push_word;
                head_ok_q <= tail_ok_q || push;
                tail_ok_q <= tail_ok_q && push;
                if (tail_ok_q && push) begin
                    tail_q <= push_word;
                end
            end else if (push) begin
                if (!head_ok_q) begin
                    head_q    <= push_word;
                    head_ok_q <= 1'b1;
                end else begin
                    tail_q    <= push_word;
                    tail_ok_q <= 1'b1;
                end
            end
            if (word_end && full) begin
                o_overrun <= 1'b1;
            end
        end
    end

    assign o_valid = head_ok_q;
    assign o_word  = head_q;

    // Descriptor ring; prefetch always points one entry ahead
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_cur_index      <= 5'h00;
            o_prefetch_index <= SILS_RING_STEP;
        end else if (i_desc_advance) begin
            o_cur_index      <= o_prefetch_index;
            o_prefetch_index <= o_prefetch_index + SILS_RING_STEP;
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    property p_or_combine;
        bit_edge && !frame_rise && !ctrl_q.steer |=> first_sh_q[0] == $past(|line_s2_q);
    endproperty
    a_or_combine: assert property (p_or_combine) else $error("lines not ORed");

    property p_second_off;
        push && !steer_word_q |-> !push_word.second_ok && push_word.second[0] == 1'b0;
    endproperty
    a_second_off: assert property (p_second_off) else $error("second pair active");

    property p_line1;
        bit_edge && !frame_rise && ctrl_q.steer && ctrl_q.first_sel == SILS_SEL_LINE1
            |=> first_sh_q[0] == $past(line_s2_q[1]);
    endproperty
    a_line1: assert property (p_line1) else $error("first pair wrong line");

    property p_second_line2;
        bit_edge && !frame_rise && ctrl_q.steer && ctrl_q.second_sel == SILS_SEL_LINE2
            |=> second_sh_q[0] == $past(line_s2_q[2]);
    endproperty
    a_second_line2: assert property (p_second_line2) else $error("second pair wrong");

    property p_first_line0;
        bit_edge && !frame_rise && ctrl_q.steer && ctrl_q.first_sel == SILS_SEL_LINE0
            |=> first_sh_q[0] == $past(line_s2_q[0]);
    endproperty
    a_first_line0: assert property (p_first_line0) else $error("first pair not line 0");

    property p_reserved_zero;
        bit_edge && !frame_rise && ctrl_q.steer && ctrl_q.first_sel == SILS_SEL_RESERVED
            |=> first_sh_q[0] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not idle");

    property p_last_read;
        i_read_done && i_read_tag == 3'h2 |=> last_read_q == SILS_SEL_LINE1 [*1];
    endproperty
    a_last_read: assert property (p_last_read) else $error("last read line wrong");

    property p_ring_wrap;
        i_desc_advance && o_cur_index == SILS_RING_LAST |=> o_cur_index == 5'h00;
    endproperty
    a_ring_wrap: assert property (p_ring_wrap) else $error("ring did not wrap");

    property p_prefetch;
        i_desc_advance |=> o_cur_index == $past(o_prefetch_index)
            && o_prefetch_index == $past(o_prefetch_index) + SILS_RING_STEP;
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch lagging");

    c_steer_word: cover property (push && steer_word_q);
    c_overrun:    cover property (word_end && full);
    c_wrap:       cover property (i_desc_advance && o_cur_index == SILS_RING_LAST);
endmodule // sils_steer
`default_nettype wire

// ### sils_pkg.sv
// Package for the serial input line steering block: map register and stream types
package sils_pkg;
    // Input line map register
    localparam logic [7:0] SILS_MAP_OFFSET    = 8'h80;
    localparam logic [7:0] SILS_MAP_RESET     = 8'h00;
    localparam int         SILS_SEL2_LSB      = 6;
    localparam int         SILS_SEL1_LSB      = 4;
    localparam int         SILS_STEER_BIT     = 3;
    localparam int         SILS_LAST_LSB      = 0;
    // Line select encodings
    localparam logic [1:0] SILS_SEL_LINE0     = 2'h0;
    localparam logic [1:0] SILS_SEL_LINE1     = 2'h1;
    localparam logic [1:0] SILS_SEL_LINE2     = 2'h2;
    localparam logic [1:0] SILS_SEL_RESERVED  = 2'h3;
    // Serial lines, bits per word, descriptor ring
    localparam int         SILS_LINES         = 3;
    localparam logic [2:0] SILS_BIT_LAST      = 3'h7;
    localparam logic [4:0] SILS_RING_LAST     = 5'h1f;
    localparam logic [4:0] SILS_RING_STEP     = 5'h01;

    typedef logic [1:0] sils_sel_t;

    // One assembled byte for each engine pair
    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic       second_ok;
    } sils_word_t;

    // Control fields held in the map register
    typedef struct packed {
        sils_sel_t second_sel;
        sils_sel_t first_sel;
        logic      steer;
    } sils_ctrl_t;
endpackage

// ### sils_codec_model.sv
// Codec-side model: frame sync, gated bit clock and three serial lines
`timescale 1ns/1ns
`default_nettype none
module sils_codec_model (
    // Frame request from the bench
    input  wire logic        i_go,
    input  wire logic        i_slow,
    input  wire logic [23:0] i_data,
    // Link pins
    output logic             o_bit_clock,
    output logic             o_frame_sync,
    output logic [2:0]       o_line,
    output logic             o_busy
);
    localparam int HALF      = 32;  // Half of the 64 ns bit clock
    localparam int LEAD_SLOW = 96;  // Longer sync lead-in, same bit clock
    // Bit clock stands still low between frames
    initial begin
        o_bit_clock = 1'b0;
        o_frame_sync = 1'b0;
        o_line = 3'h5;
        o_busy = 1'b0;
    end
    // Pins move 1 ns off the bench clock edge, so no race with its sampling;
    // lines change on the rising edge, held well past the falling edge
    always @(posedge i_go) begin
        #1;
        o_busy = 1'b1;
        o_frame_sync = 1'b1;
        #(i_slow ? LEAD_SLOW : HALF);
        for (int b = 7; b >= 0; b--) begin
            o_line = {i_data[16+b], i_data[8+b], i_data[b]};
            o_bit_clock = 1'b1;
            #(HALF);
            o_bit_clock = 1'b0;
            #(HALF);
        end
        o_frame_sync = 1'b0;
        o_line = ~o_line; // Released: no stale bit left showing
        // Idle gap so the next frame sync is seen as a fresh rise
        #(HALF);
        o_busy = 1'b0;
    end
endmodule // sils_codec_model
`default_nettype wire

// ### tb.sv
// Bench for line steering: map register, steering modes, buffer, ring index
`timescale 1ns/1ns
`default_nettype none
module tb
    import sils_pkg::*;
;
    logic        clk, rst_n, wr_s, rd_s, go, slow, done, adv, rdy, bclk, fsync, busy;
    logic        valid, ovr;
    logic [7:0]  addr, wdata, rdata, map, w, a, off;
    logic [2:0]  line, tag, t;
    logic [23:0] data, d;
    logic [23:0] q [3];
    logic [4:0]  cur, pre, n;
    logic [1:0]  last;
    sils_word_t  word;
    int          check_count, n_mismatch, cyc;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    sils_steer dut (.i_clock(clk), .i_rst_n(rst_n), .i_reg_wr(wr_s), .i_reg_rd(rd_s),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_bit_clock(bclk),
        .i_frame_sync(fsync), .i_serial_input_line(line), .i_read_done(done),
        .i_read_tag(tag), .o_valid(valid), .o_word(word), .i_ready(rdy), .o_overrun(ovr),
        .i_desc_advance(adv), .o_cur_index(cur), .o_prefetch_index(pre));
    sils_codec_model codec (.i_go(go), .i_slow(slow), .i_data(data), .o_bit_clock(bclk),
        .o_frame_sync(fsync), .o_line(line), .o_busy(busy));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Byte-wide accesses only; an idle edge between strobes
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        wr_s <= 1'b1;
        addr <= ad;
        wdata <= dt;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] ad);
        rd_s <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic send(input logic [23:0] dt);
        int k = 0;
        data <= dt;
        slow <= 1'($urandom);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy && k < 400) begin
            @(posedge clk);
            k++;
        end
    endtask
    // Wait bounded for a word, compare, then pop it
    task automatic take(input sils_word_t e);
        int k = 0;
        @(negedge clk);
        while (valid !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        chk({valid, word}, {1'b1, e});
        @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk);
        rdy <= 1'b0;
    endtask
    function automatic logic [7:0] pk(input logic [23:0] dt, input logic [1:0] s);
        return (s == 2'h3) ? 8'h00 : dt[8*s+:8];
    endfunction
    // Expected word from the map and the three line bytes
    function automatic sils_word_t ew(input logic [7:0] m, input logic [23:0] dt);
        if (m[3] == 1'b0) begin
            return {dt[7:0] | dt[15:8] | dt[23:16], 8'h00, 1'b0};
        end
        return {pk(dt, m[5:4]), pk(dt, m[7:6]), 1'b1};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        rst_n = 1'b0;
        {wr_s, rd_s, go, slow, done, adv, rdy} = '0;
        {addr, wdata, tag, data} = '0;
        last = 2'h0;
        void'($urandom(32'hcc2bf028));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h80);
        chk(rdata, 8'h00);
        // Map writes, stray addresses and read-line tags
        for (int i = 0; i < 12; i++) begin
            w = 8'($urandom);
            a = 8'($urandom) | 8'h01;
            t = 3'($urandom);
            done <= 1'b1;
            tag <= t;
            @(posedge clk);
            done <= 1'b0;
            last = t[0] ? 2'h0 : t[1] ? 2'h1 : t[2] ? 2'h2 : last;
            wr(a, ~w);
            wr(8'h80, w);
            rd(8'h80);
            chk(rdata, {w[7:3], 1'b0, last});
            rd(a);
            chk(rdata, {w[7:3], 1'b0, last});
        end
        // Ring index, many back-to-back advances, wraps past 31
        n = 5'h00;
        off = 8'h00;
        for (int i = 0; i < 80; i++) begin
            t = 3'($urandom);
            adv <= |t[1:0];
            @(negedge clk);
            chk(cur, n);
            chk(pre, 5'(n + 5'h01));
            chk({cur, 3'h0}, off);
            n = n + {4'h0, |t[1:0]};
            // Software byte offset of the entry, wraps after the last one
            if (|t[1:0]) begin
                off = (off == {SILS_RING_LAST, 3'h0}) ? 8'h00 : off + 8'h08;
            end
            @(posedge clk);
        end
        // Each buffer split in two: long descriptor, then short tail
        for (int i = 0; i < 4; i++) begin
            adv <= 1'b1;
            repeat (2) @(posedge clk);
            adv <= 1'b0;
            n = n + 5'h02;
            @(negedge clk);
            chk(cur, n);
            chk(pre, 5'(n + 5'h01));
            @(posedge clk);
        end
        // Every select pair with steering on, then steering off
        for (int k = 0; k < 20; k++) begin
            w = (k < 16) ? {4'(k), 1'b1, 3'($urandom)} : {4'($urandom), 1'b0, 3'($urandom)};
            wr(8'h80, w);
            map = w;
            d = 24'($urandom);
            send(d);
            take(ew(map, d));
        end
        // Receiver stalls: two words kept, third dropped
        for (int i = 0; i < 3; i++) begin
            q[i] = 24'($urandom);
            chk(ovr, 1'b0);
            send(q[i]);
        end
        @(negedge clk);
        chk(ovr, 1'b1);
        take(ew(map, q[0]));
        take(ew(map, q[1]));
        @(negedge clk);
        chk(valid, 1'b0);
        // Mid-run reset: sticky overrun, ring and read data back to idle
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({ovr, valid, cur, pre}, {1'b0, 1'b0, 5'h00, 5'h01});
        chk(rdata, 8'h00);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
